// ---- ccpm_cfg.svh ----
// Constants of the CPU clock and power-mode controller: offsets, bit positions, reset values, counts.
// Assumes inclusion by bare name from the package only; the design modules use its macros without including it.
`ifndef CCPM_CFG_SVH
`define CCPM_CFG_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CCPM_OFS_REG_A      5'h00
`define CCPM_OFS_REG_B      5'h04
`define CCPM_OFS_REG_C      5'h08
`define CCPM_OFS_DIVIDE     5'h0C
`define CCPM_OFS_PLL        5'h10
`define CCPM_OFS_PROC_B     5'h14
`define CCPM_OFS_STATUS     5'h18
// ----------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------
`define CCPM_A_PERIPH_STOP  2
`define CCPM_A_DRIVE_HIGH   3
`define CCPM_A_SUB_EN       4
`define CCPM_A_MAIN_STOP    5
`define CCPM_A_SUB_SEL      7
`define CCPM_B_ALL_STOP     0
`define CCPM_B_PLL_SEL      7
`define CCPM_C_BASE_SEL     1
`define CCPM_PLL_EN         7
`define CCPM_PB_BUS_WAIT    2
// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define CCPM_RST_DIVIDE     5'h08
`define CCPM_RST_DRIVE_HIGH 1'b1
`define CCPM_DRAIN_CYCLES   3'h4
`define CCPM_DIV32_LAST     5'h1F
`endif

// ---- ccpm_pkg.sv ----
// Types of the CPU clock and power-mode controller.
// Assumes ccpm_cfg.svh on the include path.
package ccpm_pkg;
  `include "ccpm_cfg.svh"
  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CCPM_RUN        = 3'b000,  // CPU clocked
    CCPM_WAIT_DRAIN = 3'b001,  // Queue drains before wait
    CCPM_WAITING    = 3'b010,  // CPU clock held
    CCPM_STOP_DRAIN = 3'b011,  // Queue drains before stop
    CCPM_STOPPED    = 3'b100   // All oscillators off
  } ccpm_mode_t;
  typedef enum logic [1:0] {
    CCPM_SRC_MAIN = 2'b00,
    CCPM_SRC_PLL  = 2'b01,
    CCPM_SRC_BASE = 2'b10,     // Sub clock as base source, divided
    CCPM_SRC_SUB  = 2'b11      // Sub clock undivided
  } ccpm_src_t;
  // ----------------------------------------------------------------
  // Whole state of the controller
  // ----------------------------------------------------------------
  typedef struct packed {
    ccpm_mode_t  mode;
    logic [2:0]  drain_cnt;
    logic [7:0]  reg_a;
    logic [7:0]  reg_b;
    logic [7:0]  reg_c;
    logic [4:0]  divide;
    logic [7:0]  pll;
    logic [7:0]  proc_b;
    ccpm_src_t   cur_src;
    logic [4:0]  cur_div;
    logic [4:0]  div_cnt;
    logic [7:0]  main_cnt;
    logic [7:0]  sub_cnt;
    logic [4:0]  d32_cnt;
    logic        cpu_en;
    logic        per_en;
    logic        d32_en;
    logic        strap_done;
    logic        rom_block;
    logic        main_on;   // Level outputs, registered
    logic        sub_on;
    logic        pll_on;
    logic        in_wait;
    logic        in_stop;
    logic        hready;
    logic        wr;
    logic [2:0]  addr;
    logic [31:0] hrdata;
  } ccpm_state_t;
endpackage : ccpm_pkg

// ---- ccpm_sync.sv ----
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to sys_clk.
`timescale 1ns/10ps
module ccpm_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  initial begin
    if (WIDTH < 1) $error("ccpm_sync: WIDTH must be at least 1");
  end
  logic [WIDTH-1:0] meta_q;  // First stage, read by second stage only
  // ----------------------------------------------------------------
  // Two stages, no reset
  // ----------------------------------------------------------------
  // Pins flush through while reset is held, so the boot strap is
  // already valid at the first edge after release
  always_ff @(posedge sys_clk) begin
    meta_q   <= async_in;
    sync_out <= meta_q;
  end
endmodule : ccpm_sync

// ---- ccpm_ctrl.sv ----
// CPU clock selection, divider and wait/stop control with an AHB-Lite register slave.
// Assumes one clock sys_clk; oscillator activity is modelled as tick enables prescaled from sys_clk here (MAIN_RATIO, SUB_RATIO),
// and all pins pass ccpm_sync before use.
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
// Summary of operation
// [RULE1] Boot pin high at reset blocks ROM reads
// [RULE2] Fast CPU clocks come from PLL multiplication
// [RULE3] Software sets low drive when sub clock used
// [RULE4] Sub start: deselect, high drive, enable, low
// [RULE5] Stop entry forces sub drive high
// [RULE6] Software selects main clock before stop
// [RULE7] After stop, wait, low drive, reselect sub
// [RULE8] External main clock never stopped while used
// [RULE9] No bus wait state while changing divider
// [RULE10] Peripheral stop wait needs CPU <=10 MHz
// [RULE11] Wait entry lets four queued instructions pass; five or more pass if the CPU clock period is under three sys_clk cycles
// [RULE12] Drop PLL and select main before stop
// [RULE13] Stop refused while interrupt pin low
// [RULE14] Hold reset until main oscillator stable
// [RULE15] Dummy interrupt before stopping again after wake
// [RULE16] Queued instructions run on stop exit first
// [RULE17] Divided-by-32 sub clock runs during wait
// [RULE18] No peripheral-stop wait in low-speed modes
// [RULE19] Switch only to stably oscillating sources
// [RULE20] Source and divider switch without CPU glitches
module ccpm_ctrl
  import ccpm_pkg::*;
#(
  parameter int MAIN_RATIO = 2,  // sys_clk cycles per main oscillator tick
  parameter int SUB_RATIO  = 8   // sys_clk cycles per sub oscillator tick
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        boot_mode_pin,
  input  wire logic        nmi_n_pin,
  input  wire logic        main_osc_stable,
  input  wire logic        sub_osc_stable,
  input  wire logic        pll_locked,
  input  wire logic        wait_req,
  input  wire logic        irq_wake,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             sub_div32_clock,
  output logic             main_osc_en,
  output logic             sub_osc_en,
  output logic             sub_osc_drive_high,
  output logic             pll_en,
  output logic             wait_mode,
  output logic             stop_mode,
  output logic             rom_read_block
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (MAIN_RATIO < 1 || MAIN_RATIO > 256) $error("ccpm_ctrl: MAIN_RATIO out of range");
    if (SUB_RATIO < 1 || SUB_RATIO > 256) $error("ccpm_ctrl: SUB_RATIO out of range");
  end

  localparam logic [7:0] MAIN_LAST = 8'(MAIN_RATIO - 1);  // Last main prescale count
  localparam logic [7:0] SUB_LAST  = 8'(SUB_RATIO - 1);   // Last sub prescale count

  ccpm_state_t s_q;           // Registered state
  ccpm_state_t s_d;           // Next state
  logic [4:0]  pin_s;         // Synchronised pins
  logic        boot_s;        // Boot strap level
  logic        nmi_s;         // Interrupt pin, high when idle
  logic        main_ok;       // Main oscillator stable
  logic        sub_ok;        // Sub oscillator stable
  logic        pll_ok;        // PLL locked

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ccpm_sync #(.WIDTH(5)) u_sync (
    .sys_clk  (sys_clk),
    .async_in ({boot_mode_pin, nmi_n_pin, main_osc_stable, sub_osc_stable, pll_locked}),
    .sync_out (pin_s)
  );
  assign {boot_s, nmi_s, main_ok, sub_ok, pll_ok} = pin_s;

  // Divider field to last divider count; zero means undivided
  function automatic logic [4:0] div_last(input logic [4:0] field);
    div_last = (field == 5'h00) ? 5'h00 : 5'(field - 5'h01);
  endfunction : div_last

  // Register read mux by word index
  function automatic logic [31:0] read_reg(input ccpm_state_t s, input logic [2:0] idx,
                                           input logic [2:0] stat);
    read_reg = 32'h00000000;
    case (idx)
      3'h0:    read_reg[7:0] = s.reg_a;
      3'h1:    read_reg[7:0] = s.reg_b;
      3'h2:    read_reg[7:0] = s.reg_c;
      3'h3:    read_reg[4:0] = s.divide;
      3'h4:    read_reg[7:0] = s.pll;
      3'h5:    read_reg[7:0] = s.proc_b;
      3'h6:    read_reg[11:0] = {s.cur_src, s.mode, s.rom_block, s.strap_done, stat, 2'b00};
      default: read_reg = 32'h00000000;  // Unmapped reads as zero
    endcase
  endfunction : read_reg

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    ccpm_src_t  want_src;  // Source software asks for
    logic       main_tick;
    logic       sub_tick;
    logic       src_tick;
    logic       halted;
    want_src  = CCPM_SRC_MAIN;
    main_tick = 1'b0;
    sub_tick  = 1'b0;
    src_tick  = 1'b0;
    halted    = 1'b0;
    s_d = s_q;
    s_d.cpu_en = 1'b0;
    s_d.per_en = 1'b0;
    s_d.d32_en = 1'b0;

    // Strap caught once, in the cycle after reset release
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.rom_block  = boot_s;  // see [RULE1]
    end

    // Data phase: one wait state, then write or read
    if (!s_q.hready) begin
      s_d.hready = 1'b1;
      if (s_q.wr) begin
        case (s_q.addr)
          3'h0: s_d.reg_a = hwdata[7:0];
          3'h1: begin
            s_d.reg_b = hwdata[7:0];
            s_d.reg_b[`CCPM_B_ALL_STOP] = 1'b0;
            // Stop is refused while the interrupt pin is low
            if (hwdata[`CCPM_B_ALL_STOP] && nmi_s && s_q.mode == CCPM_RUN) begin  // see [RULE13]
              s_d.reg_b[`CCPM_B_ALL_STOP] = 1'b1;
              s_d.mode      = CCPM_STOP_DRAIN;
              s_d.drain_cnt = `CCPM_DRAIN_CYCLES;
            end
          end
          3'h2: s_d.reg_c  = hwdata[7:0];
          3'h3: s_d.divide = hwdata[4:0];
          3'h4: s_d.pll    = hwdata[7:0];
          3'h5: s_d.proc_b = hwdata[7:0];
          default: ;  // Unmapped and status writes ignored
        endcase
      end else begin
        s_d.hrdata = read_reg(s_q, s_q.addr, {pll_ok, sub_ok, main_ok});
      end
    end
    // Address phase taken only when no data phase is pending
    if (hsel && htrans[1] && hready && s_q.hready) begin
      s_d.hready = 1'b0;
      s_d.wr     = hwrite;
      s_d.addr   = haddr[4:2];
    end

    // Power-mode sequencing
    case (s_q.mode)
      CCPM_RUN: begin
        if (wait_req) begin
          s_d.mode      = CCPM_WAIT_DRAIN;
          s_d.drain_cnt = `CCPM_DRAIN_CYCLES;
        end
      end
      CCPM_WAIT_DRAIN: begin
        // Prefetched instructions keep running before the halt
        if (s_q.drain_cnt == 3'h0) s_d.mode = CCPM_WAITING;  // see [RULE11]
        else if (s_q.cpu_en) s_d.drain_cnt = s_q.drain_cnt - 3'h1;
      end
      CCPM_WAITING: begin
        halted = 1'b1;
        if (irq_wake || !nmi_s) s_d.mode = CCPM_RUN;
      end
      CCPM_STOP_DRAIN: begin
        if (s_q.drain_cnt == 3'h0) begin
          s_d.mode = CCPM_STOPPED;
        end else if (s_q.cpu_en) begin
          s_d.drain_cnt = s_q.drain_cnt - 3'h1;
        end
      end
      CCPM_STOPPED: begin
        halted = 1'b1;
        // Queued instructions run first on return, then recovery handler
        if (irq_wake || !nmi_s) begin  // see [RULE16]
          s_d.mode = CCPM_RUN;
          s_d.reg_b[`CCPM_B_ALL_STOP] = 1'b0;
        end
      end
      default: s_d.mode = CCPM_RUN;
    endcase
    // Forced after software writes so the hardware set wins
    if (s_d.mode == CCPM_STOPPED && s_q.mode != CCPM_STOPPED) begin
      s_d.reg_a[`CCPM_A_DRIVE_HIGH] = 1'b1;  // see [RULE5]
    end

    // Oscillator tick prescalers; nothing ticks in stop
    if (s_q.mode != CCPM_STOPPED && main_ok && !s_q.reg_a[`CCPM_A_MAIN_STOP]) begin
      main_tick    = (s_q.main_cnt == MAIN_LAST);
      s_d.main_cnt = main_tick ? 8'h00 : s_q.main_cnt + 8'h01;
    end
    if (s_q.mode != CCPM_STOPPED && sub_ok && s_q.reg_a[`CCPM_A_SUB_EN]) begin
      sub_tick    = (s_q.sub_cnt == SUB_LAST);
      s_d.sub_cnt = sub_tick ? 8'h00 : s_q.sub_cnt + 8'h01;
    end
    // Divided-by-32 sub clock ignores wait and peripheral stop
    if (sub_tick) begin  // see [RULE17]
      s_d.d32_en  = (s_q.d32_cnt == `CCPM_DIV32_LAST);
      s_d.d32_cnt = s_q.d32_cnt + 5'h01;
    end

    // Requested source
    if (s_q.reg_a[`CCPM_A_SUB_SEL]) want_src = CCPM_SRC_SUB;
    else if (s_q.reg_c[`CCPM_C_BASE_SEL]) want_src = CCPM_SRC_BASE;
    else if (s_q.reg_b[`CCPM_B_PLL_SEL]) want_src = CCPM_SRC_PLL;
    else want_src = CCPM_SRC_MAIN;

    case (s_q.cur_src)
      CCPM_SRC_MAIN: src_tick = main_tick;
      CCPM_SRC_PLL:  src_tick = (s_q.mode != CCPM_STOPPED) && pll_ok && s_q.pll[`CCPM_PLL_EN];
      default:       src_tick = sub_tick;
    endcase

    // Divider counts source ticks; new setting taken only at a period end
    if (src_tick) begin
      if (s_q.div_cnt >= s_q.cur_div) begin  // see [RULE20]
        s_d.div_cnt = 5'h00;
        s_d.cpu_en  = !halted;
        s_d.per_en  = !(halted && s_q.mode == CCPM_WAITING && s_q.reg_a[`CCPM_A_PERIPH_STOP]);
        s_d.cur_src = want_src;
        s_d.cur_div = (want_src == CCPM_SRC_SUB) ? 5'h00 : div_last(s_q.divide);
      end else begin
        s_d.div_cnt = s_q.div_cnt + 5'h01;
      end
    end

    // Level outputs registered from the next state, so they follow it at once
    s_d.main_on = (s_d.mode != CCPM_STOPPED) & !s_d.reg_a[`CCPM_A_MAIN_STOP];
    s_d.sub_on  = (s_d.mode != CCPM_STOPPED) & s_d.reg_a[`CCPM_A_SUB_EN];
    s_d.pll_on  = (s_d.mode != CCPM_STOPPED) & s_d.pll[`CCPM_PLL_EN];
    s_d.in_wait = (s_d.mode == CCPM_WAITING);
    s_d.in_stop = (s_d.mode == CCPM_STOPPED);
  end

  // ----------------------------------------------------------------
  // State register, synchronous reset
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_q        <= '0;
      s_q.mode   <= CCPM_RUN;
      s_q.reg_a  <= 8'h00 | (8'(`CCPM_RST_DRIVE_HIGH) << `CCPM_A_DRIVE_HIGH);
      s_q.divide <= `CCPM_RST_DIVIDE;
      s_q.cur_div <= div_last(`CCPM_RST_DIVIDE);
      s_q.cur_src <= CCPM_SRC_MAIN;
      s_q.hready <= 1'b1;
      s_q.main_on <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs from state flops; hresp tied to OKAY
  // ----------------------------------------------------------------
  assign hrdata             = s_q.hrdata;
  assign hreadyout          = s_q.hready;
  assign hresp              = 1'b0;  // Always OKAY
  assign cpu_clk_en         = s_q.cpu_en;
  assign periph_clk_en      = s_q.per_en;
  assign sub_div32_clock    = s_q.d32_en;
  assign main_osc_en        = s_q.main_on;
  assign sub_osc_en         = s_q.sub_on;
  assign sub_osc_drive_high = s_q.reg_a[`CCPM_A_DRIVE_HIGH];
  assign pll_en             = s_q.pll_on;
  assign wait_mode          = s_q.in_wait;
  assign stop_mode          = s_q.in_stop;
  assign rom_read_block     = s_q.rom_block;
endmodule : ccpm_ctrl

// ---- ccpm_monitor.sv ----
// Checker for the CPU clock and power-mode controller.
// Sees only ports of ccpm_ctrl; the bind sits at the foot of this file.
`timescale 1ns/10ps
module ccpm_monitor #(
  parameter int MAIN_RATIO = 2,  // Cycles per main tick
  parameter int SUB_RATIO  = 8   // Cycles per sub tick
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hreadyout,
  input wire logic nmi_n_pin,
  input wire logic wait_req,
  input wire logic irq_wake,
  input wire logic cpu_clk_en,
  input wire logic sub_div32_clock,
  input wire logic sub_osc_en,
  input wire logic sub_osc_stable,
  input wire logic sub_osc_drive_high,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic rom_read_block
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic       pend_q;  // Wait accepted, no wake yet
  logic [2:0] cnt_q;   // CPU clocks since the wait request
  int         gap_q;   // Cycles since the last divided sub pulse
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Count CPU clocks after a wait request; any wake ends the watch
  always_ff @(posedge sys_clk) begin
    if (!reset_n || irq_wake || !nmi_n_pin) begin
      pend_q <= 1'b0;
      cnt_q  <= 3'h0;
    end else if (wait_req && !wait_mode && !stop_mode) begin
      pend_q <= 1'b1;
      cnt_q  <= 3'h0;
    end else if (pend_q && cpu_clk_en && cnt_q != 3'h7) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  // Gap restarts while the sub oscillator is off, since no pulse can come then
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !sub_osc_en || !sub_osc_stable || sub_div32_clock) begin
      gap_q <= 0;
    end else begin
      gap_q <= gap_q + 1;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_rom_lock;
    reset_n && $past(reset_n) && $past(reset_n, 2) && $past(reset_n, 3) |-> $stable(rom_read_block);
  endproperty
  a_rom_lock: assert property (p_rom_lock)
    else $error("rom block changed outside reset");
  property p_stop_drive;
    stop_mode |-> sub_osc_drive_high;
  endproperty
  a_stop_drive: assert property (p_stop_drive)
    else $error("drive low during stop");
  property p_wait_drain;
    pend_q && cnt_q == 3'h4 |-> !cpu_clk_en;
  endproperty
  a_wait_drain: assert property (p_wait_drain)
    else $error("fifth cpu clock after wait request");
  property p_stop_refuse;
    !nmi_n_pin [*4] |-> !$rose(stop_mode);
  endproperty
  a_stop_refuse: assert property (p_stop_refuse)
    else $error("stop entered with interrupt pin low");
  property p_stop_resume;
    $fell(stop_mode) |-> ##[1:300] cpu_clk_en;
  endproperty
  a_stop_resume: assert property (p_stop_resume)
    else $error("cpu clock did not resume after stop");
  property p_d32_runs;
    wait_mode |-> gap_q < 32 * SUB_RATIO + 8;
  endproperty
  a_d32_runs: assert property (p_d32_runs)
    else $error("divided sub clock halted in wait");
  property p_no_runt;
    cpu_clk_en |=> !cpu_clk_en;
  endproperty
  a_no_runt: assert property (p_no_runt)
    else $error("runt cpu clock period");
  property p_bus_one_wait;
    !hreadyout |=> hreadyout;
  endproperty
  a_bus_one_wait: assert property (p_bus_one_wait) // Data phase is two cycles
    else $error("bus wait longer than one cycle");
endmodule : ccpm_monitor

bind ccpm_ctrl ccpm_monitor #(.MAIN_RATIO(MAIN_RATIO), .SUB_RATIO(SUB_RATIO)) i_ccpm_monitor (.*);

// ---- ccpm_osc_model.sv ----
// Oscillator partner: main, sub and PLL settle after their enables rise.
// Assumes enables from ccpm_ctrl; slow stretches every settling time fourfold.
`timescale 1ns/10ps
module ccpm_osc_model #(
  parameter int MAIN_SETTLE = 4,   // Main settles before reset ends
  parameter int SUB_SETTLE  = 40,  // Sub is the slowest starter
  parameter int PLL_SETTLE  = 8
) (
  input  wire logic sys_clk,
  input  wire logic slow,
  input  wire logic main_osc_en,
  input  wire logic sub_osc_en,
  input  wire logic pll_en,
  output logic      main_osc_stable,
  output logic      sub_osc_stable,
  output logic      pll_locked
);
  int mc = 0;  // Cycles since main enabled
  int sc = 0;  // Cycles since sub enabled
  int pc = 0;  // Cycles since PLL enabled
  int k;       // Settle stretch
  // A disabled source loses stability at once; a running one never stops
  always @(posedge sys_clk) begin
    k = slow ? 4 : 1;
    mc <= main_osc_en ? mc + 1 : 0;
    sc <= sub_osc_en ? sc + 1 : 0;
    pc <= pll_en ? pc + 1 : 0;
    main_osc_stable <= main_osc_en && mc >= k * MAIN_SETTLE;
    sub_osc_stable  <= sub_osc_en && sc >= k * SUB_SETTLE;
    pll_locked      <= pll_en && pc >= k * PLL_SETTLE;
  end
endmodule : ccpm_osc_model

// ---- tb.sv ----
// Self-checking bench of ccpm_ctrl with an oscillator partner.
// Assumes ccpm_pkg, ccpm_monitor and ccpm_osc_model compiled first.
`timescale 1ns/10ps
module tb;
  import ccpm_pkg::*;
  logic        sys_clk, reset_n, hsel, hwrite, hresp, boot_mode_pin, nmi_n_pin, slow;
  logic        main_osc_stable, sub_osc_stable, pll_locked, wait_req, irq_wake, hreadyout;
  logic        cpu_clk_en, periph_clk_en, sub_div32_clock, main_osc_en, sub_osc_en;
  logic        sub_osc_drive_high, pll_en, wait_mode, stop_mode, rom_read_block;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [15:0] rnd = 16'hECEE;  // Seed 60654
  wire         hready = hreadyout;  // Single slave drives bus ready
  int          fails, cmp_count, cyc, cpu_n, per_n, d32_n, c, p, s, k;
  int          mdl [8] = '{'h08, 0, 0, 'h08, 0, 0, 0, 0};  // Register model
  int          mk [8] = '{'hBC, 'h80, 'h02, 'h1F, 'h80, 'h04, 0, 0};  // Bits the model keeps per register
  int          wm [6] = '{'h04, 0, 0, 'h1F, 'h80, 'h04};  // Random bits that keep a live source
  ccpm_ctrl #(.SUB_RATIO(2)) i_ccpm_ctrl (.hsize(3'h2), .*);
  ccpm_osc_model i_ccpm_osc_model (.*);
  // ----------------------------------------
  // Clock, pulse counters and hang guard
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    cpu_n += int'(cpu_clk_en === 1'b1);
    per_n += int'(periph_clk_en === 1'b1);
    d32_n += int'(sub_div32_clock === 1'b1);
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done();
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    cmp_count++;
    if (v !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, v);
    end
  endtask : chk
  // One AHB-Lite single transfer; waits only on hready
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {27'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] wd);
    logic [31:0] r;
    bus(1'b1, a, wd, r);
    if (a < 5'h18) mdl[a[4:2]] = wd & mk[a[4:2]];
  endtask : wr
  task automatic rd(input logic [4:0] a);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk("register", mdl[a[4:2]], r);
  endtask : rd
  task automatic reset(input logic b);
    boot_mode_pin <= b;
    reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("rom_read_block", b, rom_read_block);
  endtask : reset
  task automatic pulse_wake();
    @(posedge sys_clk);
    irq_wake <= 1'b1;
    @(posedge sys_clk);
    irq_wake <= 1'b0;
  endtask : pulse_wake
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {hsel, hwrite, wait_req, irq_wake, slow, htrans, haddr, hwdata} = '0;
    nmi_n_pin = 1'b1;
    reset(1'b0);
    for (int i = 0; i < 8; i++) if (i != 6) rd(5'(i * 4));
    // Random stored bits, an unmapped word and the read-only status
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      k = rnd % 6;
      d = {16'h0, rnd} & wm[k];
      if (k == 3 && d < 2) d = 2;
      slow <= rnd[0];
      wr(5'(k * 4), d);
      rd(5'(k * 4));
      chk("pll_en", mdl[4][7], pll_en);
    end
    wr(5'h1C, 32'hFFFF_FFFF);
    rd(5'h1C);
    wr(5'h18, 32'hFFFF_FFFF);
    bus(1'b0, 5'h18, 32'h0, d);
    chk("status", 32'h0000_0024, d & 32'hFFFF_FFEF);
    // Main clock divided by two, sub started with high drive first
    wr(5'h10, 32'h0);
    wr(5'h0C, 32'h2);
    wr(5'h00, 32'h18);
    wait (sub_osc_stable === 1'b1);
    wr(5'h00, 32'h14);
    chk("drive", 0, sub_osc_drive_high);
    // Wait entry with peripheral stop
    @(posedge sys_clk);
    wait_req <= 1'b1;
    @(posedge sys_clk);
    wait_req <= 1'b0;
    #1 c = cpu_n;
    repeat (60) @(posedge sys_clk);
    chk("wait_mode", 1, wait_mode);
    #1 p = per_n;
    s = d32_n;
    repeat (200) @(posedge sys_clk);
    #1 chk("cpu clocks after wait", 4, cpu_n - c);
    chk("periph in wait", 0, per_n - p);
    chk("d32 runs", 1, d32_n > s);
    pulse_wake();
    repeat (40) @(posedge sys_clk);
    chk("wait_mode", 0, wait_mode);
    // Stop refused while the interrupt pin is low
    nmi_n_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(5'h04, 32'h1);
    repeat (30) @(posedge sys_clk);
    chk("stop refused", 0, stop_mode);
    rd(5'h04);
    nmi_n_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Stop accepted, then woken
    wr(5'h04, 32'h1);
    repeat (100) @(posedge sys_clk);
    chk("stop_mode", 1, stop_mode);
    chk("drive forced", 1, sub_osc_drive_high);
    chk("main_osc_en", 0, main_osc_en);
    mdl[0] |= 'h08;
    #1 c = cpu_n;
    pulse_wake();
    repeat (100) @(posedge sys_clk);
    chk("stop_mode", 0, stop_mode);
    #1 chk("cpu resumed", 1, cpu_n > c);
    rd(5'h04);
    rd(5'h00);
    // Sub clock reselected once stable, low drive, undivided
    wait (sub_osc_stable === 1'b1);
    wr(5'h00, 32'h94);
    repeat (10) @(posedge sys_clk);
    bus(1'b0, 5'h18, 32'h0, d);
    chk("status", 32'h0000_0C2C, d);
    reset(1'b1);
    test_done();
  end
endmodule : tb
